// *** pkg/csss_pkg.sv ***
package csss_pkg;

   localparam logic [7:0]  REG_TRIM      = 8'h00;
   localparam logic [7:0]  REG_CTRL      = 8'h04;
   localparam logic [7:0]  REG_STAT      = 8'h08;
   localparam int          CTRL_PLL_BIT  = 0;
   localparam int          CTRL_PD_BIT   = 1;

   localparam logic [3:0]  CSEL_PLL      = 4'h1;
   localparam logic [3:0]  CSEL_RC       = 4'h2;
   localparam logic [3:0]  CSEL_LEG      = 4'h3;
   localparam logic [3:0]  CSEL_LP       = 4'h4;
   localparam logic [1:0]  SUT_00        = 2'h0;
   localparam logic [1:0]  SUT_01        = 2'h1;
   localparam logic [1:0]  SUT_10        = 2'h2;
   localparam logic [1:0]  SUT_11        = 2'h3;
   localparam logic        FUSE_PROG     = 1'b0;

   localparam int          CKW           = 15;
   localparam int          WDW           = 14;
   localparam logic [14:0] CK_1          = 15'h0001;
   localparam logic [14:0] CK_6          = 15'h0006;
   localparam logic [14:0] CK_14         = 15'h000e;
   localparam logic [14:0] CK_1K         = 15'h0400;
   localparam logic [14:0] CK_16K        = 15'h4000;
   localparam logic [13:0] WDT_NONE      = 14'h0000;
   localparam logic [13:0] WDT_4MS       = 14'h0200;
   localparam logic [13:0] WDT_64MS      = 14'h2000;

   // Nominal frequencies in kHz, for reference by the clock tree.
   localparam int          PLL_KHZ       = 64000;
   localparam int          PLL_SYS_KHZ   = 16000;
   localparam int          RC_KHZ        = 8000;
   localparam int          LEG_RC_KHZ    = 6400;
   localparam int          LEG_SYS_KHZ   = 1600;
   localparam int          LEG_PCK_KHZ   = 25600;
   localparam int          LP_KHZ        = 128;
   localparam int          SYS_DIV       = 4;

   typedef enum logic [1:0] {SRC_RC, SRC_PLL, SRC_LP} csss_src_t;

   typedef enum logic [1:0] {ST_CK, ST_WDT, ST_RUN, ST_PD} csss_st_t;

   typedef struct packed {
      logic [3:0] csel;
      logic [1:0] startup_delay_fuses;
      logic       rst_pin_dis;
   } csss_fuse_t;

   typedef struct packed {
      csss_src_t src;
      logic      sys_div4;
      logic      pll_en;
      logic      pll_x4;
      logic      rc_6m4;
      logic      osc_run;
   } csss_cfg_t;

   typedef struct packed {
      csss_st_t        st;
      logic [CKW-1:0]  ck_left;
      logic [WDW-1:0]  wdt_left;
      logic [7:0]      trim;
      logic            pll_sw;
      logic            cpu_en;
      csss_cfg_t       cfg;
      logic [31:0]     prdata;
   } csss_state_t;

endpackage

// *** hw/csss_clock_startup.sv ***
`timescale 1ns/1ps
module csss_clock_startup
(
   input  wire logic                clk_sys,       // System clock, 40 MHz.
   input  wire logic                rst_b,         // Synchronous reset, active low.
   input  wire csss_pkg::csss_fuse_t fuses,        // Clock select, delay, reset pin fuses.
   input  wire logic [7:0]          factory_trim,  // Factory calibration byte.
   input  wire logic                src_ck_tick,   // One pulse per selected source cycle.
   input  wire logic                wdt_tick,      // One pulse per watchdog osc cycle.
   input  wire logic                reset_req,     // System reset pulse.
   input  wire logic                wake_req,      // Wake from power-down pulse.
   input  wire logic                psel,          // APB select.
   input  wire logic                penable,       // APB enable.
   input  wire logic                pwrite,        // APB direction.
   input  wire logic [7:0]          paddr,         // APB byte address.
   input  wire logic [31:0]         pwdata,        // APB write data.
   output logic [31:0]              prdata,        // APB read data.
   output logic                     pready,        // APB ready.
   output logic                     pslverr,       // APB error on unmapped address.
   output csss_pkg::csss_cfg_t      clk_cfg,       // Clock tree steering.
   output logic [7:0]               osc_trim,      // Trim to the RC oscillator.
   output logic                     cpu_clk_en     // Processor clock gate.
);

   csss_pkg::csss_state_t s_q;
   csss_pkg::csss_state_t s_d;
   logic [csss_pkg::CKW-1:0] ck_wake;
   logic [csss_pkg::CKW-1:0] ck_rst;
   logic [csss_pkg::WDW-1:0] wdt_wake;
   logic [csss_pkg::WDW-1:0] wdt_rst;
   logic                     addr_ok;
   logic                     wr_acc;
   logic                     unsup;
   logic [31:0]              rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Start-up delay decode.

   always_comb
   begin
      ck_wake  = csss_pkg::CK_6;
      ck_rst   = csss_pkg::CK_14;
      wdt_wake = csss_pkg::WDT_NONE;
      wdt_rst  = csss_pkg::WDT_NONE;
      unsup    = 1'b0;
      unique case (fuses.csel)
         csss_pkg::CSEL_PLL:
         begin
            ck_wake  = csss_pkg::CK_14 + (fuses.startup_delay_fuses[0] ? csss_pkg::CK_16K
                                                      : csss_pkg::CK_1K);
            wdt_wake = fuses.startup_delay_fuses[1] ? csss_pkg::WDT_64MS : csss_pkg::WDT_4MS;
            ck_rst   = '0;
            wdt_rst  = csss_pkg::WDT_4MS;
         end
         csss_pkg::CSEL_LEG:
         begin
            unique case (fuses.startup_delay_fuses)
               csss_pkg::SUT_10: wdt_rst = csss_pkg::WDT_4MS;
               csss_pkg::SUT_11:
               begin
                  ck_wake = csss_pkg::CK_1;
                  wdt_rst = csss_pkg::WDT_NONE;
               end
               default: wdt_rst = csss_pkg::WDT_64MS;
            endcase
         end
         default:
         begin
            // RC 8 MHz and 128 kHz share one table; reserved code 11 takes the longest.
            unsup = (fuses.csel != csss_pkg::CSEL_RC) && (fuses.csel != csss_pkg::CSEL_LP);
            unique case (fuses.startup_delay_fuses)
               csss_pkg::SUT_00: wdt_rst = csss_pkg::WDT_NONE;
               csss_pkg::SUT_01: wdt_rst = csss_pkg::WDT_4MS;
               default:          wdt_rst = csss_pkg::WDT_64MS;
            endcase
         end
      endcase
      if ((fuses.rst_pin_dis == csss_pkg::FUSE_PROG) && (wdt_rst == csss_pkg::WDT_NONE))
      begin
         wdt_rst = csss_pkg::WDT_4MS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode.

   assign addr_ok = (paddr == csss_pkg::REG_TRIM) || (paddr == csss_pkg::REG_CTRL)
                    || (paddr == csss_pkg::REG_STAT);
   assign wr_acc  = psel && penable && pwrite && addr_ok;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_comb
   begin
      rd_mux = '0;
      unique case (paddr)
         csss_pkg::REG_TRIM: rd_mux = {24'h000000, s_q.trim};
         csss_pkg::REG_CTRL: rd_mux = {31'h00000000, s_q.pll_sw};
         csss_pkg::REG_STAT: rd_mux = {20'h00000, fuses.csel, 2'h0, fuses.startup_delay_fuses,
                                       unsup, s_q.st == csss_pkg::ST_WDT,
                                       s_q.st == csss_pkg::ST_PD, s_q.cpu_en};
         default:            rd_mux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_comb
   begin
      s_d = s_q;
      if (psel && !penable)
      begin
         s_d.prdata = rd_mux;
      end
      if (wr_acc && (paddr == csss_pkg::REG_TRIM))
      begin
         s_d.trim = pwdata[7:0];
      end
      if (wr_acc && (paddr == csss_pkg::REG_CTRL))
      begin
         s_d.pll_sw = pwdata[csss_pkg::CTRL_PLL_BIT];
      end
      unique case (s_q.st)
         csss_pkg::ST_CK:
         begin
            if (s_q.ck_left == '0)
            begin
               s_d.st = (s_q.wdt_left == '0) ? csss_pkg::ST_RUN : csss_pkg::ST_WDT;
            end
            else if (src_ck_tick)
            begin
               s_d.ck_left = s_q.ck_left - 1'b1;
            end
         end
         csss_pkg::ST_WDT:
         begin
            if (s_q.wdt_left == '0)
            begin
               s_d.st = csss_pkg::ST_RUN;
            end
            else if (wdt_tick)
            begin
               s_d.wdt_left = s_q.wdt_left - 1'b1;
            end
         end
         csss_pkg::ST_RUN:
         begin
            if (wr_acc && (paddr == csss_pkg::REG_CTRL) && pwdata[csss_pkg::CTRL_PD_BIT])
            begin
               s_d.st = csss_pkg::ST_PD;
            end
         end
         csss_pkg::ST_PD:
         begin
            if (wake_req)
            begin
               s_d.st       = csss_pkg::ST_CK;
               s_d.ck_left  = ck_wake;
               s_d.wdt_left = wdt_wake;
            end
         end
      endcase
      if (reset_req)
      begin
         s_d.st       = csss_pkg::ST_CK;
         s_d.ck_left  = ck_rst;
         s_d.wdt_left = wdt_rst;
         s_d.trim     = factory_trim;
         s_d.pll_sw   = 1'b0;
      end
      s_d.cpu_en = (s_d.st == csss_pkg::ST_RUN);
      unique case (fuses.csel)
         csss_pkg::CSEL_PLL: s_d.cfg.src = csss_pkg::SRC_PLL;
         csss_pkg::CSEL_LP:  s_d.cfg.src = csss_pkg::SRC_LP;
         default:            s_d.cfg.src = csss_pkg::SRC_RC;
      endcase
      s_d.cfg.sys_div4 = (fuses.csel == csss_pkg::CSEL_PLL)
                         || (fuses.csel == csss_pkg::CSEL_LEG);
      s_d.cfg.osc_run  = (s_d.st != csss_pkg::ST_PD);
      s_d.cfg.pll_en   = s_d.cfg.osc_run && ((fuses.csel == csss_pkg::CSEL_PLL)
                         || (fuses.csel == csss_pkg::CSEL_LEG) || s_d.pll_sw);
      s_d.cfg.pll_x4   = (fuses.csel == csss_pkg::CSEL_LEG);
      s_d.cfg.rc_6m4   = (fuses.csel == csss_pkg::CSEL_LEG);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         s_q              <= '0;
         s_q.st           <= csss_pkg::ST_CK;
         s_q.ck_left      <= ck_rst;
         s_q.wdt_left     <= wdt_rst;
         s_q.trim         <= factory_trim;
         s_q.cfg.src      <= csss_pkg::SRC_RC;
         s_q.cfg.osc_run  <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata     = s_q.prdata;
   assign clk_cfg    = s_q.cfg;
   assign osc_trim   = s_q.trim;
   assign cpu_clk_en = s_q.cpu_en;

endmodule // csss_clock_startup

// *** tb/csss_clock_startup_assertions.sv ***
`timescale 1ns/1ps
module csss_startup_checker
(
   input wire logic                 clk_sys,      // Clock.
   input wire logic                 rst_b,        // Reset.
   input wire csss_pkg::csss_fuse_t fuses,        // Fuses.
   input wire logic [7:0]           factory_trim, // Factory trim.
   input wire logic                 src_ck_tick,  // Source tick.
   input wire logic                 wdt_tick,     // Watchdog tick.
   input wire logic                 reset_req,    // Reset request.
   input wire logic                 psel,         // Select.
   input wire logic                 penable,      // Enable.
   input wire logic                 pwrite,       // Direction.
   input wire logic [7:0]           paddr,        // Address.
   input wire logic [31:0]          pwdata,       // Write data.
   input wire csss_pkg::csss_cfg_t  clk_cfg,      // Clock steering.
   input wire logic [7:0]           osc_trim,     // Trim.
   input wire logic                 cpu_clk_en    // Clock gate.
);
   wire logic wr = psel && penable && pwrite;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   a_trim_reload:
      assert property (disable iff (1'b0) (!rst_b || reset_req) |=> osc_trim == $past(factory_trim))
      else $error("trim not reloaded");
   a_trim_write:
      assert property (wr && paddr == csss_pkg::REG_TRIM && !reset_req |=> osc_trim == $past(pwdata[7:0]))
      else $error("trim write lost");
   a_reset_gate:
      assert property (reset_req |=> !cpu_clk_en) else $error("clock not gated on reset");
   a_run_holds:
      assert property (cpu_clk_en && !reset_req && !(wr && paddr == csss_pkg::REG_CTRL) |=> cpu_clk_en)
      else $error("clock gate dropped");
   a_rise_tick:
      assert property ($rose(cpu_clk_en) |-> $past(src_ck_tick || wdt_tick, 2))
      else $error("release without tick");
   a_pll_cfg:
      assert property (cpu_clk_en && $stable(fuses) && fuses.csel == csss_pkg::CSEL_PLL |->
         clk_cfg.src == csss_pkg::SRC_PLL && clk_cfg.sys_div4 && clk_cfg.pll_en)
      else $error("pll steering wrong");
   a_rc_cfg:
      assert property (cpu_clk_en && $stable(fuses) && fuses.csel == csss_pkg::CSEL_RC |->
         clk_cfg.src == csss_pkg::SRC_RC && !clk_cfg.sys_div4 && !clk_cfg.rc_6m4 && clk_cfg.osc_run)
      else $error("rc steering wrong");
   a_leg_cfg:
      assert property (cpu_clk_en && $stable(fuses) && fuses.csel == csss_pkg::CSEL_LEG |->
         clk_cfg.src == csss_pkg::SRC_RC && clk_cfg.sys_div4 && clk_cfg.rc_6m4 && clk_cfg.pll_x4)
      else $error("legacy steering wrong");
   a_lp_cfg:
      assert property (cpu_clk_en && $stable(fuses) && fuses.csel == csss_pkg::CSEL_LP |->
         clk_cfg.src == csss_pkg::SRC_LP && !clk_cfg.sys_div4)
      else $error("low power steering wrong");
endmodule // csss_startup_checker

bind csss_clock_startup csss_startup_checker i_chk (.clk_sys, .rst_b, .fuses, .factory_trim,
   .src_ck_tick, .wdt_tick, .reset_req, .psel, .penable, .pwrite, .paddr, .pwdata, .clk_cfg,
   .osc_trim, .cpu_clk_en);

// *** tb/csss_clock_startup_tb.sv ***
`timescale 1ns/1ps
module csss_clock_startup_tb;
   typedef struct {csss_pkg::csss_fuse_t f; logic wk; int ck; int wd;} csss_row_t;
   logic                 clk_sys, rst_b, src_ck_tick, wdt_tick, reset_req, wake_req;
   logic                 psel, penable, pwrite, pready, pslverr, cpu_clk_en, se;
   logic [7:0]           paddr, factory_trim, osc_trim;
   logic [31:0]          pwdata, prdata, rd;
   csss_pkg::csss_fuse_t fuses;
   csss_pkg::csss_cfg_t  clk_cfg;
   int                   err_count, comparisons;
   csss_row_t rows [14] = '{
      '{'{4'h2, 2'h0, 1'b1}, 0, 14, 0},
      '{'{4'h2, 2'h0, 1'b0}, 0, 14, 512},
      '{'{4'h2, 2'h1, 1'b1}, 0, 14, 512},
      '{'{4'h2, 2'h2, 1'b1}, 0, 14, 8192},
      '{'{4'h4, 2'h1, 1'b1}, 0, 14, 512},
      '{'{4'h3, 2'h3, 1'b1}, 0, 14, 0},
      '{'{4'h3, 2'h3, 1'b1}, 1, 1, 0},
      '{'{4'h3, 2'h2, 1'b1}, 0, 14, 512},
      '{'{4'h3, 2'h0, 1'b1}, 0, 14, 8192},
      '{'{4'h1, 2'h0, 1'b1}, 0, 0, 512},
      '{'{4'h1, 2'h0, 1'b1}, 1, 1038, 512},
      '{'{4'h1, 2'h1, 1'b1}, 0, 0, 512},
      '{'{4'h1, 2'h1, 1'b1}, 1, 16398, 512},
      '{'{4'h4, 2'h0, 1'b0}, 0, 14, 512}};

   csss_clock_startup i_csss_clock_startup (.clk_sys, .rst_b, .fuses, .factory_trim,
      .src_ck_tick, .wdt_tick, .reset_req, .wake_req, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .clk_cfg, .osc_trim, .cpu_clk_en);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         close_out();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic seq(input int ck, input int wd);
      for (int i = 0; i < ck + wd; i++)
      begin
         if (i == ck + wd - 1) chk("early", 0, cpu_clk_en);
         @(posedge clk_sys);
         if (i < ck) src_ck_tick <= 1'b1;
         else wdt_tick <= 1'b1;
         @(posedge clk_sys);
         {src_ck_tick, wdt_tick} <= 2'b00;
      end
      repeat (2) @(posedge clk_sys);
      chk("released", 1, cpu_clk_en);
   endtask

   task close_out;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      close_out();
   end

   initial
   begin
      {rst_b, src_ck_tick, wdt_tick, reset_req, wake_req, psel, penable, pwrite} = 8'h00;
      {paddr, pwdata, err_count, comparisons} = '0;
      fuses = '{4'h2, 2'h2, 1'b1};
      factory_trim = 8'h5a;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      chk("trim", 8'h5a, osc_trim);
      chk("gate", 0, cpu_clk_en);
      apb(1'b1, csss_pkg::REG_TRIM, 32'h33);
      apb(1'b1, csss_pkg::REG_CTRL, 32'h1);
      apb(1'b0, csss_pkg::REG_TRIM, 32'h0);
      chk("trim_rd", 32'h33, rd);
      chk("trim_out", 8'h33, osc_trim);
      chk("pll_en", 1, clk_cfg.pll_en);
      apb(1'b0, 8'h3c, 32'h0);
      chk("unmapped", 33'h1_0000_0000, {se, rd});
      apb(1'b0, csss_pkg::REG_STAT, 32'h0);
      chk("status", 32'h0000_0220, rd);
      foreach (rows[i])
      begin
         fuses <= rows[i].f;
         if (rows[i].wk)
         begin
            apb(1'b1, csss_pkg::REG_CTRL, 32'h2);
            repeat (2) @(posedge clk_sys);
            chk("powerdown", 0, {cpu_clk_en, clk_cfg.osc_run});
            wake_req <= 1'b1;
         end
         else reset_req <= 1'b1;
         @(posedge clk_sys);
         {wake_req, reset_req} <= 2'b00;
         seq(rows[i].ck, rows[i].wd);
         chk("trim_reload", 8'h5a, osc_trim);
      end
      close_out();
   end
endmodule // csss_clock_startup_tb
